// >>> design/ldfc_core.sv
/*
  Feature-control register and cascade logic of an 8-digit LED driver:
  serial shift register on the serial clock, frame latch, control and
  digit storage, blink timing.
  Assumes the host stops the serial clock before raising the latch strobe
  and holds the frame steady until the core has taken it.
*/
// Summary of operation
// - font bit picks decimal or hex decode
// - port-enable bit gates the shift interface
// - slew-limited variant keeps the port always on
// - blink-enable bit alternates lit and dark
// - period bit picks one or two seconds
// - align bit clears blink counter on strobe
// - start bit picks first blink phase
// - strobe rising edge latches the frame
// - no_operation_command leaves registers, command updates target
// - feature register clears at power-up
// - soft reset defaults control regs, not digits
// - clock bit picks internal or serial clock
module ldfc_core import ldfc_pkg::*; #(
  parameter bit SLEW_LIMITED = 1'b1, // 1: port can not be disabled
  parameter int SHORT_HALF_CYC = BLINK_SHORT_HALF_CYC, // shorten in sim
  parameter int LONG_HALF_CYC = BLINK_LONG_HALF_CYC
) (
  input wire logic core_clk_i, // internal oscillator clock
  input wire logic rst_i, // active high; synchronous in the core domain, asynchronous in the link domain
  input wire logic serial_clk_i, // link clock from the host
  input wire logic serial_din_i, // serial data in
  input wire logic latch_strobe_i, // frame latch, rising edge
  output logic serial_dout_o, // serial data to next driver
  output logic [7:0] feature_o, // feature_control contents
  output ldfc_ctrl_t ctrl_o, // other control registers
  output logic [63:0] digits_o, // digit registers, digit 0 low
  output logic font_hex_o, // 1 hex font, 0 decimal font
  output logic port_en_o, // shift interface enabled
  output logic sys_clk_ext_o, // serial clock is system clock
  output logic display_lit_o // blink phase: display lit
);
  // ----------------------------------------------------------------
  // link domain: shift register and edge toggle
  // ----------------------------------------------------------------
  logic en_s1_reg, en_s2_reg; // port enable into link domain
  logic en_s1_next, en_s2_next;
  logic [15:0] shift_reg, shift_next; // 16-bit frame shifter
  logic dout_reg, dout_next; // registered chain output
  logic tgl_reg, tgl_next; // flips on each serial edge
  logic port_en_reg; // core side port enable

  // next state of the link side
  always_comb begin
    en_s1_next = port_en_reg;
    en_s2_next = en_s1_reg;
    tgl_next = ~tgl_reg; // event for external clock mode
    shift_next = shift_reg;
    dout_next = dout_reg;
    if (en_s2_reg) begin
      shift_next = {shift_reg[14:0], serial_din_i};
      // new msb, so the next driver takes it exactly sixteen edges on
      dout_next = shift_reg[14];
    end
  end

  // link clock may stop between frames, so reset acts without it
  always_ff @(posedge serial_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // same value as the core side, so no bit of the first frame is lost
      en_s1_reg <= SLEW_LIMITED;
      en_s2_reg <= SLEW_LIMITED;
      shift_reg <= SHIFT_RST;
      dout_reg <= 1'b0;
      tgl_reg <= 1'b0;
    end else begin
      en_s1_reg <= en_s1_next;
      en_s2_reg <= en_s2_next;
      shift_reg <= shift_next;
      dout_reg <= dout_next;
      tgl_reg <= tgl_next;
    end
  end

  assign serial_dout_o = dout_reg;

  // ----------------------------------------------------------------
  // core domain: synchronisers
  // ----------------------------------------------------------------
  logic [2:0] lat_sync_reg, lat_sync_next; // strobe sync plus history
  logic [2:0] tgl_sync_reg, tgl_sync_next; // serial edge event
  logic latch_rise; // one-cycle pulse per strobe rise
  logic ext_tick; // one serial edge seen
  ldfc_frame_t frame; // frame held by the stopped shifter

  // bit 0 feeds only bit 1; edges use bits 1 and 2
  always_comb begin
    lat_sync_next = {lat_sync_reg[1:0], latch_strobe_i};
    tgl_sync_next = {tgl_sync_reg[1:0], tgl_reg};
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lat_sync_reg <= 3'h0;
      tgl_sync_reg <= 3'h0;
    end else begin
      lat_sync_reg <= lat_sync_next;
      tgl_sync_reg <= tgl_sync_next;
    end
  end

  assign latch_rise = lat_sync_reg[1] & ~lat_sync_reg[2];
  assign ext_tick = tgl_sync_reg[1] ^ tgl_sync_reg[2];
  // quasi-static: the shifter does not move while the strobe is high
  assign frame = ldfc_frame_t'(shift_reg);

  // ----------------------------------------------------------------
  // core domain: register file
  // ----------------------------------------------------------------
  logic [7:0] feature_reg, feature_next;
  ldfc_ctrl_t ctrl_reg, ctrl_next;
  logic [63:0] digits_reg, digits_next;
  logic port_en_next;
  logic [3:0] digit_idx; // digit slot of the frame address

  // latched frame decode; no_operation_command matches only the default branch
  always_comb begin
    feature_next = feature_reg;
    ctrl_next = ctrl_reg;
    digits_next = digits_reg;
    digit_idx = frame.addr - ADDR_DIGIT_FIRST;
    if (latch_rise) begin
      if (frame.addr == ADDR_FEATURE) begin
        feature_next = frame.data;
      end else if (frame.addr >= ADDR_DIGIT_FIRST && frame.addr <= ADDR_DIGIT_LAST) begin
        digits_next[digit_idx[2:0] * 8 +: 8] = frame.data;
      end else begin
        case (frame.addr)
          ADDR_DECODE: ctrl_next.decode_en = frame.data;
          ADDR_INTENSITY: ctrl_next.intensity = frame.data;
          ADDR_SCAN: ctrl_next.scan_limit = frame.data;
          ADDR_SHUTDOWN: ctrl_next.shutdown = frame.data;
          default: ctrl_next = ctrl_reg; // no_operation_command and unused slots
        endcase
      end
    end
    // held at defaults while soft reset is set; digits untouched
    if (feature_next[FEAT_SOFT_RST]) begin
      ctrl_next = ldfc_ctrl_t'(CTRL_RST);
    end
    port_en_next = SLEW_LIMITED | feature_next[FEAT_PORT_EN];
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      feature_reg <= FEATURE_RST;
      ctrl_reg <= ldfc_ctrl_t'(CTRL_RST);
      digits_reg <= DIGITS_RST;
      port_en_reg <= SLEW_LIMITED;
    end else begin
      feature_reg <= feature_next;
      ctrl_reg <= ctrl_next;
      digits_reg <= digits_next;
      port_en_reg <= port_en_next;
    end
  end

  assign feature_o = feature_reg;
  assign ctrl_o = ctrl_reg;
  assign digits_o = digits_reg;
  assign font_hex_o = feature_reg[FEAT_FONT_HEX];
  assign port_en_o = port_en_reg;
  assign sys_clk_ext_o = feature_reg[FEAT_EXT_CLK];

  // ----------------------------------------------------------------
  // core domain: blink timing
  // ----------------------------------------------------------------
  localparam logic [BLINK_CNT_W-1:0] SHORT_LAST = BLINK_CNT_W'(SHORT_HALF_CYC - 1);
  localparam logic [BLINK_CNT_W-1:0] LONG_LAST = BLINK_CNT_W'(LONG_HALF_CYC - 1);
  logic [BLINK_CNT_W-1:0] cnt_reg, cnt_next; // cycles into half period
  logic phase_reg, phase_next; // 1 lit half, 0 dark half
  logic lit_reg, lit_next;
  logic [BLINK_CNT_W-1:0] half_last; // last count of a half period
  logic tick; // timebase step
  logic restart; // put the blink back to its start

  // counter, phase and lit output
  always_comb begin
    half_last = feature_reg[FEAT_BLINK_SLOW] ? LONG_LAST : SHORT_LAST;
    // external clock mode counts serial edges instead of core cycles
    tick = feature_reg[FEAT_EXT_CLK] ? ext_tick : 1'b1;
    restart = ~feature_reg[FEAT_BLINK_EN]
      | (latch_rise & feature_reg[FEAT_BLINK_ALIGN]);
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    if (restart) begin
      cnt_next = '0;
      // start bit of the same write counts
      phase_next = feature_next[FEAT_BLINK_START];
    end else if (tick) begin
      if (cnt_reg >= half_last) begin
        cnt_next = '0;
        phase_next = ~phase_reg;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
    // blink off keeps the display lit
    lit_next = ~feature_next[FEAT_BLINK_EN] | phase_next;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      phase_reg <= 1'b0;
      lit_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      lit_reg <= lit_next;
    end
  end

  assign display_lit_o = lit_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_FONT_LATCH: assert property (
    latch_rise && frame.addr == ADDR_FEATURE |=> font_hex_o == $past(frame.data[FEAT_FONT_HEX]))
    else $error("font bit not taken from feature frame");
  AST_PORT_EN: assert property (
    port_en_o == (SLEW_LIMITED || feature_o[FEAT_PORT_EN]))
    else $error("port enable did not follow feature bit");
  AST_SLEW_ON: assert property (
    SLEW_LIMITED |-> port_en_o)
    else $error("slew-limited variant port disabled");
  AST_BLINK_OFF: assert property (
    !feature_o[FEAT_BLINK_EN] |-> display_lit_o)
    else $error("display dark with blinking off");
  AST_HALF_LEN: assert property (
    feature_o[FEAT_BLINK_EN] && !restart && tick && cnt_reg < half_last
      |=> !$changed(phase_reg))
    else $error("blink phase changed before half period end");
  AST_ALIGN: assert property (
    latch_rise && feature_reg[FEAT_BLINK_ALIGN] |=> cnt_reg == '0)
    else $error("align strobe did not clear blink counter");
  AST_START: assert property (
    $rose(feature_o[FEAT_BLINK_EN]) |-> display_lit_o == feature_o[FEAT_BLINK_START])
    else $error("blink did not begin in start phase");
  AST_LATCH: assert property (
    latch_rise && frame.addr == ADDR_INTENSITY && !feature_reg[FEAT_SOFT_RST]
      && !frame.data[FEAT_SOFT_RST] |=> ctrl_o.intensity == $past(frame.data))
    else $error("intensity frame not latched");
  AST_NOOP: assert property (
    latch_rise && frame.addr == ADDR_NOOP
      |=> $stable(feature_o) && $stable(digits_o) && $stable(ctrl_o))
    else $error("no_operation_command frame changed a register");
  AST_SOFT_RST: assert property (
    feature_o[FEAT_SOFT_RST] |-> ctrl_o == ldfc_ctrl_t'(CTRL_RST))
    else $error("soft reset left control register set");
  AST_DOUT: assert property (@(posedge serial_clk_i) disable iff (rst_i)
    en_s2_reg |=> serial_dout_o == $past(shift_reg[14]))
    else $error("serial output not sixteen edges late");

  COV_FEATURE_WRITE: cover property (latch_rise && frame.addr == ADDR_FEATURE);
  COV_NOOP: cover property (latch_rise && frame.addr == ADDR_NOOP);
  COV_PHASE_FLIP: cover property (feature_o[FEAT_BLINK_EN] ##1 $changed(phase_reg));
  COV_ALIGN: cover property (latch_rise && feature_reg[FEAT_BLINK_ALIGN] && cnt_reg != '0);
endmodule : ldfc_core

// >>> pkg/ldfc_pkg.sv
/*
  Constants, field positions and carrier types of the LED driver feature
  and cascade logic. Assumes a 10 MHz core clock and 16-bit serial frames.
*/
package ldfc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_KHZ = 10000; // core clock rate in kHz
  localparam int BLINK_SHORT_HALF_MS = 500; // 0.5 s on, 0.5 s off
  localparam int BLINK_LONG_HALF_MS = 1000; // 1 s on, 1 s off
  localparam int BLINK_SHORT_HALF_CYC = BLINK_SHORT_HALF_MS * CORE_CLK_KHZ;
  localparam int BLINK_LONG_HALF_CYC = BLINK_LONG_HALF_MS * CORE_CLK_KHZ;
  localparam int BLINK_CNT_W = 24; // holds the long half period
  // ----------------------------------------------------------------
  // frame addresses (low nibble of the address byte)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_NOOP = 4'h0;
  localparam logic [3:0] ADDR_DIGIT_FIRST = 4'h1;
  localparam logic [3:0] ADDR_DIGIT_LAST = 4'h8;
  localparam logic [3:0] ADDR_DECODE = 4'h9;
  localparam logic [3:0] ADDR_INTENSITY = 4'hA;
  localparam logic [3:0] ADDR_SCAN = 4'hB;
  localparam logic [3:0] ADDR_SHUTDOWN = 4'hC;
  localparam logic [3:0] ADDR_FEATURE = 4'hE;
  // ----------------------------------------------------------------
  // feature_control bit positions
  // ----------------------------------------------------------------
  localparam int FEAT_EXT_CLK = 0;
  localparam int FEAT_SOFT_RST = 1;
  localparam int FEAT_FONT_HEX = 2;
  localparam int FEAT_PORT_EN = 3;
  localparam int FEAT_BLINK_EN = 4;
  localparam int FEAT_BLINK_SLOW = 5;
  localparam int FEAT_BLINK_ALIGN = 6;
  localparam int FEAT_BLINK_START = 7;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FEATURE_RST = 8'h00;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [63:0] DIGITS_RST = 64'h0;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] spare; // ignored upper address bits
    logic [3:0] addr; // target register
    logic [7:0] data; // value
  } ldfc_frame_t;
  typedef struct packed {
    logic [7:0] decode_en;
    logic [7:0] intensity;
    logic [7:0] scan_limit;
    logic [7:0] shutdown;
  } ldfc_ctrl_t;
endpackage : ldfc_pkg

// >>> test/ldfc_host_model.sv
/*
  Host model: drives serial clock, data and latch strobe of a driver chain.
  Assumes drivers shift on the rising link clock and latch on a rising strobe.
*/
module ldfc_host_model (
  output logic serial_clk_o, // link clock, idle low
  output logic serial_dout_o, // data to first driver
  output logic latch_strobe_o // shared by all drivers
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF_NS = 62.5; // 125 ns link period
  initial begin
    serial_clk_o = 1'b0;
    serial_dout_o = 1'b0;
    latch_strobe_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // shift one chain word msb first, then latch it
  // ----------------------------------------------------------------
  task automatic send(input logic [31:0] word);
    int i;
    #(HALF_NS);
    for (i = 31; i >= 0; i--) begin
      serial_dout_o = word[i];
      #(HALF_NS);
      serial_clk_o = 1'b1;
      #(HALF_NS);
      serial_clk_o = 1'b0;
    end
    // released data line must not look like the last bit
    serial_dout_o = ~word[0];
    #(300);
    latch_strobe_o = 1'b1; // link clock stays stopped meanwhile
    #(1000);
    latch_strobe_o = 1'b0;
    #(500);
  endtask : send
endmodule : ldfc_host_model

// >>> test/ldfc_core_tb_top.sv
/*
  Testbench: two chained drivers fed by the host model, self-checking.
  Assumes shortened blink half periods and the slew-limited variant.
*/
module ldfc_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ldfc_pkg::*;
  localparam int SHORT = 20; // shortened half periods
  localparam int LONG = 40;
  logic core_clk, rst, sclk, din, strobe;
  logic [1:0] dout, hex, pen, ext, lit; // index = chain position
  logic [7:0] feat [2];
  ldfc_ctrl_t ctrl [2];
  logic [63:0] dig [2];
  logic [15:0] hist = '0; // link data history
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  // ----------------------------------------------------------------
  // chain of two drivers and the host
  // ----------------------------------------------------------------
  for (genvar k = 0; k < 2; k++) begin : g_chain
    ldfc_core #(.SHORT_HALF_CYC(SHORT), .LONG_HALF_CYC(LONG)) u_dut (
      .core_clk_i(core_clk), .rst_i(rst), .serial_clk_i(sclk),
      .serial_din_i(k == 0 ? din : dout[0]), .latch_strobe_i(strobe),
      .serial_dout_o(dout[k]), .feature_o(feat[k]), .ctrl_o(ctrl[k]),
      .digits_o(dig[k]), .font_hex_o(hex[k]), .port_en_o(pen[k]),
      .sys_clk_ext_o(ext[k]), .display_lit_o(lit[k]));
  end
  ldfc_host_model u_host (.serial_clk_o(sclk), .serial_dout_o(din), .latch_strobe_o(strobe));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  function automatic logic [15:0] frm(input logic [3:0] a, input logic [7:0] d);
    return {4'h0, a, d};
  endfunction : frm
  // f1 is shifted first so it ends in the second driver
  task automatic wr(input logic [15:0] f0, input logic [15:0] f1);
    u_host.send({f1, f0});
    repeat (4) @(negedge core_clk);
  endtask : wr
  // cycles until the blink phase of driver k flips
  task automatic gap(input int k, output int n);
    logic v;
    v = lit[k];
    n = 0;
    while (lit[k] === v && n < 200) begin
      @(negedge core_clk);
      n++;
    end
  endtask : gap
  // ----------------------------------------------------------------
  // link monitor and hang guard
  // ----------------------------------------------------------------
  always @(posedge sclk) hist <= {hist[14:0], din};
  // skipped while reset is unknown or high, as at time zero
  always @(negedge sclk) if (rst === 1'b0) check("chain output", dout[0], hist[15]);
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    int n;
    logic [7:0] v;
    logic [63:0] edig;
    rst = 1'b1;
    void'($urandom(79));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("feature reset", feat[0], 8'h00);
    check("ctrl reset", ctrl[0], 32'h0);
    check("port on", pen, 2'b11);
    $display("test reset done");
    // random feature values; soft reset kept clear here
    for (i = 0; i < 8; i++) begin
      v = 8'($urandom()) & 8'hFD;
      wr(frm(ADDR_FEATURE, v), frm(ADDR_NOOP, 8'($urandom())));
      check("feature", feat[0], v);
      check("font", hex[0], v[FEAT_FONT_HEX]);
      check("ext clock", ext[0], v[FEAT_EXT_CLK]);
      check("port kept on", pen[0], 1'b1);
      check("noop feature", feat[1], 8'h00);
    end
    $display("test feature done");
    edig = '0;
    for (i = 1; i <= 8; i++) begin
      v = 8'($urandom());
      edig[8*(i-1) +: 8] = v;
      wr(frm(ADDR_NOOP, 8'hFF), frm(4'(i), v));
      check("digits", dig[1], edig);
      check("noop digits", dig[0], 64'h0);
    end
    wr(frm(ADDR_NOOP, 8'h00), frm(ADDR_INTENSITY, 8'h05));
    wr(frm(ADDR_NOOP, 8'h00), frm(4'hD, 8'h77)); // unmapped address
    wr(frm(ADDR_NOOP, 8'h00), frm(4'hF, 8'h77));
    check("intensity", ctrl[1].intensity, 8'h05);
    check("unmapped", dig[1], edig);
    wr(frm(ADDR_NOOP, 8'h00), frm(ADDR_FEATURE, 8'h02));
    check("soft reset ctrl", ctrl[1], 32'h0);
    check("soft reset digits", dig[1], edig);
    check("soft reset feature", feat[1], 8'h02);
    wr(frm(ADDR_NOOP, 8'h00), frm(ADDR_FEATURE, 8'h00));
    $display("test registers done");
    // start phase and period, each combination
    for (i = 0; i < 4; i++) begin
      v = {i[0], 1'b0, i[1], 5'h00};
      wr(frm(ADDR_FEATURE, v), frm(ADDR_NOOP, 8'h00));
      repeat (50) begin
        @(negedge core_clk);
        check("blink off", lit[0], 1'b1);
      end
      wr(frm(ADDR_FEATURE, v | 8'h10), frm(ADDR_NOOP, 8'h00));
      check("first phase", lit[0], v[7]);
      gap(0, n);
      gap(0, n);
      check("half period", n, i[1] ? LONG : SHORT);
    end
    $display("test blink done");
    // driver 1 started and driver 0, already blinking, given its align bit by one strobe, then driver 0 restarted alone by its align bit, so the two run apart
    wr(frm(ADDR_FEATURE, 8'hD0), frm(ADDR_FEATURE, 8'h90));
    repeat (7 + $urandom_range(9)) @(posedge core_clk);
    wr(frm(ADDR_NOOP, 8'h00), frm(ADDR_FEATURE, 8'hD0));
    repeat (7 + $urandom_range(9)) @(posedge core_clk);
    // both drivers aligned by one shared strobe
    wr(frm(ADDR_NOOP, 8'h00), frm(ADDR_NOOP, 8'h00));
    check("aligned phase", lit, 2'b11);
    gap(0, n);
    check("aligned flip", lit[1], lit[0]);
    $display("test align done");
    report_and_stop();
  end
endmodule : ldfc_core_tb_top
